// [design/ssr_defines.vh]
`ifndef SSR_DEFINES_VH
`define SSR_DEFINES_VH
// Register offsets on the plain register port
`define SSR_ADDR_STATUS_CONTROL 4'h0
`define SSR_ADDR_DATA_BUFFER    4'h1
`define SSR_ADDR_CLOCK_CONTROL  4'h2
`define SSR_ADDR_INT_ENABLE     4'h3
`define SSR_ADDR_INT_CONTROL    4'h4
`define SSR_ADDR_EVENT_STATUS   4'h5
`define SSR_ADDR_EVENT_MASK     4'h6
// Receive status and control fields
`define SSR_BIT_SERIAL_PORT_EN  7
`define SSR_BIT_NINE_BIT_SEL    6
`define SSR_BIT_SINGLE_REQ      5
`define SSR_BIT_CONT_RX_EN      4
`define SSR_BIT_OVERRUN         1
`define SSR_BIT_NINTH           0
// Clock control fields
`define SSR_BIT_CLK_SRC_SEL     7
`define SSR_BIT_SYNC_MODE       4
// Interrupt control fields
`define SSR_BIT_GLOBAL_IE       7
`define SSR_BIT_PERIPH_IE       6
// Event status fields
`define SSR_EV_WORD             0
`define SSR_EV_OVERRUN          1
// Reset values
`define SSR_RST_BYTE            8'h00
`define SSR_RST_EVENTS          2'h0
// Interrupt vector
`define SSR_IRQ_VECTOR          16'h0004
`endif

// [design/ssr_rx_fifo.v]
`timescale 1ns/1ps
`default_nettype none
module ssr_rx_fifo #(
	parameter WIDTH = 9
) (
	input  wire             clk,
	input  wire             rstn,
	input  wire             flush,
	input  wire             push,
	input  wire [WIDTH-1:0] push_data,
	input  wire             pop,
	output wire [WIDTH-1:0] head,
	output wire             empty,
	output wire             full
);
	reg [WIDTH-1:0] slot [0:1];
	reg             rd_ptr;
	reg             wr_ptr;
	reg [1:0]       count;

	assign head  = slot[rd_ptr];
	assign empty = (count == 2'h0);
	assign full  = (count == 2'h2);

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			slot[0] <= {WIDTH{1'b0}};
			slot[1] <= {WIDTH{1'b0}};
			rd_ptr  <= 1'b0;
			wr_ptr  <= 1'b0;
			count   <= 2'h0;
		end else if (flush) begin
			rd_ptr <= 1'b0;
			wr_ptr <= 1'b0;
			count  <= 2'h0;
		end else begin
			if (push && !full) begin
				slot[wr_ptr] <= push_data;
				wr_ptr       <= ~wr_ptr;
			end
			if (pop && !empty)
				rd_ptr <= ~rd_ptr;
			case ({push && !full, pop && !empty})
			2'b10:   count <= count + 2'h1;
			2'b01:   count <= count - 2'h1;
			default: count <= count;
			endcase
		end
	end
endmodule
`default_nettype wire

// [design/ssr_receiver.v]
`timescale 1ns/1ps
`default_nettype none
`include "ssr_defines.vh"
// Functional notes
// - Slave receive equals master receive, external clock
// - Single receive request bit ignored
// - Keep receiving during sleep when enabled
// - Completed word moves into receive buffer
// - Receive interrupt wakes sleeping core
// - Global enable sends core to vector
// - Nine-bit mode keeps ninth bit apart
// - Flag on word; interrupt only if enabled
// - Received byte read as 8 bits
// - Clearing continuous enable clears errors
// - Interrupt needs global and peripheral enables
// - Two-word buffer, overrun discards, blocks loads
// - Flag clears when buffer read empty
// - Data read loads next ninth bit
// - Shift clock from pin, never driven
module ssr_receiver (
	input  wire       clk,
	input  wire       rstn,
	input  wire       shift_clk_pin,
	input  wire       data_pin,
	input  wire       core_sleeping,
	input  wire [3:0] addr,
	input  wire [7:0] wdata,
	input  wire       wr,
	input  wire       rd,
	output reg  [7:0] rdata,
	output reg        receive_complete_flag,
	output reg        core_irq,
	output reg        core_wake,
	output reg        vector_branch,
	output reg        event_irq
);
	reg  [2:0] clk_sync;
	reg  [1:0] dat_sync;
	reg        serial_port_enable;
	reg        nine_bit_receive_select;
	reg        single_receive_request;
	reg        continuous_receive_enable;
	reg        clock_source_select;
	reg        sync_mode;
	reg        receive_interrupt_enable;
	reg        global_interrupt_enable;
	reg        peripheral_interrupt_enable;
	reg        overrun_error_flag;
	reg        received_ninth_bit;
	reg        second_ninth;
	reg  [8:0] receive_shift_register;
	reg  [3:0] bit_count;
	reg  [1:0] event_status;
	reg  [1:0] event_mask;
	wire       rise;
	wire       rx_active;
	wire [3:0] word_bits;
	wire       last_bit;
	wire [8:0] next_shift;
	wire [8:0] word_in;
	wire       fifo_full;
	wire       fifo_empty;
	wire [8:0] fifo_head;
	wire       data_read;
	wire       pop;
	wire       push;
	wire       overrun;
	wire       flush;
	wire [1:0] next_events;
	wire       next_flag;
	wire       next_irq;

	function sel;
		input [3:0] a;
		input [3:0] target;
		begin
			sel = (a == target);
		end
	endfunction

	// External clock sampled, never driven
	assign rise = clk_sync[1] & ~clk_sync[2];
	// Single request plays no part here
	assign rx_active = serial_port_enable & sync_mode &
		~clock_source_select & continuous_receive_enable;
	assign word_bits = nine_bit_receive_select ? 4'h9 : 4'h8;
	assign last_bit  = rx_active & rise &
		(bit_count == word_bits - 4'h1);
	// Bits arrive least significant first
	assign next_shift = {dat_sync[1], receive_shift_register[8:1]};
	assign word_in = nine_bit_receive_select ? next_shift :
		{1'b0, next_shift[8:1]};
	assign data_read = rd && sel(addr, `SSR_ADDR_DATA_BUFFER);
	assign pop       = data_read && !fifo_empty;
	assign push    = last_bit && !fifo_full && !overrun_error_flag;
	assign overrun = last_bit && fifo_full && !overrun_error_flag;
	assign flush   = !continuous_receive_enable;

	ssr_rx_fifo #(
		.WIDTH (9)
	) u_fifo (
		.clk       (clk),
		.rstn      (rstn),
		.flush     (1'b0),
		.push      (push),
		.push_data (word_in),
		.pop       (pop),
		.head      (fifo_head),
		.empty     (fifo_empty),
		.full      (fifo_full)
	);

	// Flag follows buffer contents; no software write
	assign next_flag = push |
		(~fifo_empty & ~(pop & ~fifo_full));
	assign next_irq = next_flag & receive_interrupt_enable &
		global_interrupt_enable & peripheral_interrupt_enable;
	// Write-one clear applied before events set, so set wins
	assign next_events = (event_status &
		~((wr && sel(addr, `SSR_ADDR_EVENT_STATUS)) ? wdata[1:0] : 2'h0)) |
		{overrun, push};

	// Input synchronisers
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			clk_sync <= 3'h0;
			dat_sync <= 2'h0;
		end else begin
			clk_sync <= {clk_sync[1:0], shift_clk_pin};
			dat_sync <= {dat_sync[0], data_pin};
		end
	end

	// Shifting runs whether or not the core sleeps
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			receive_shift_register <= 9'h000;
			bit_count              <= 4'h0;
		end else if (!rx_active) begin
			bit_count <= 4'h0;
		end else if (rise) begin
			receive_shift_register <= next_shift;
			bit_count <= last_bit ? 4'h0 : bit_count + 4'h1;
		end
	end

	// Control registers
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			serial_port_enable          <= 1'b0;
			nine_bit_receive_select     <= 1'b0;
			single_receive_request      <= 1'b0;
			continuous_receive_enable   <= 1'b0;
			clock_source_select         <= 1'b0;
			sync_mode                   <= 1'b0;
			receive_interrupt_enable    <= 1'b0;
			global_interrupt_enable     <= 1'b0;
			peripheral_interrupt_enable <= 1'b0;
			event_mask                  <= `SSR_RST_EVENTS;
		end else if (wr) begin
			if (sel(addr, `SSR_ADDR_STATUS_CONTROL)) begin
				serial_port_enable <= wdata[`SSR_BIT_SERIAL_PORT_EN];
				nine_bit_receive_select <= wdata[`SSR_BIT_NINE_BIT_SEL];
				single_receive_request <= wdata[`SSR_BIT_SINGLE_REQ];
				continuous_receive_enable <= wdata[`SSR_BIT_CONT_RX_EN];
			end
			if (sel(addr, `SSR_ADDR_CLOCK_CONTROL)) begin
				clock_source_select <= wdata[`SSR_BIT_CLK_SRC_SEL];
				sync_mode           <= wdata[`SSR_BIT_SYNC_MODE];
			end
			if (sel(addr, `SSR_ADDR_INT_ENABLE))
				receive_interrupt_enable <= wdata[0];
			if (sel(addr, `SSR_ADDR_INT_CONTROL)) begin
				global_interrupt_enable <= wdata[`SSR_BIT_GLOBAL_IE];
				peripheral_interrupt_enable <= wdata[`SSR_BIT_PERIPH_IE];
			end
			if (sel(addr, `SSR_ADDR_EVENT_MASK))
				event_mask <= wdata[1:0];
		end
	end

	// Status, ninth bit and outputs
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			overrun_error_flag    <= 1'b0;
			received_ninth_bit    <= 1'b0;
			second_ninth          <= 1'b0;
			receive_complete_flag <= 1'b0;
			core_irq              <= 1'b0;
			core_wake             <= 1'b0;
			vector_branch         <= 1'b0;
			event_status          <= `SSR_RST_EVENTS;
			event_irq             <= 1'b0;
		end else begin
			if (flush)
				overrun_error_flag <= 1'b0;
			else if (overrun)
				overrun_error_flag <= 1'b1;
			// Ninth bit of the word waiting behind the head
			if (push && !fifo_empty && !pop)
				second_ninth <= word_in[8];
			if (pop) begin
				if (fifo_full)
					received_ninth_bit <= second_ninth;
				else if (push)
					received_ninth_bit <= word_in[8];
			end else if (push && fifo_empty) begin
				received_ninth_bit <= word_in[8];
			end
			receive_complete_flag <= next_flag;
			core_irq  <= next_irq;
			core_wake <= core_sleeping & next_flag &
				receive_interrupt_enable;
			vector_branch <= core_sleeping & next_irq;
			event_status <= next_events;
			event_irq    <= |(next_events & event_mask);
		end
	end

	// Read data one cycle after the strobe
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata <= `SSR_RST_BYTE;
		end else if (rd) begin
			case (addr)
			`SSR_ADDR_STATUS_CONTROL:
				rdata <= {serial_port_enable, nine_bit_receive_select,
					single_receive_request, continuous_receive_enable,
					2'b00, overrun_error_flag, received_ninth_bit};
			`SSR_ADDR_DATA_BUFFER:
				rdata <= fifo_head[7:0];
			`SSR_ADDR_CLOCK_CONTROL:
				rdata <= {clock_source_select, 2'b00, sync_mode, 4'h0};
			`SSR_ADDR_INT_ENABLE:
				rdata <= {6'h00, receive_complete_flag,
					receive_interrupt_enable};
			`SSR_ADDR_INT_CONTROL:
				rdata <= {global_interrupt_enable,
					peripheral_interrupt_enable, 6'h00};
			`SSR_ADDR_EVENT_STATUS:
				rdata <= {6'h00, event_status};
			`SSR_ADDR_EVENT_MASK:
				rdata <= {6'h00, event_mask};
			default:
				rdata <= `SSR_RST_BYTE;
			endcase
		end else begin
			rdata <= `SSR_RST_BYTE;
		end
	end
endmodule
`default_nettype wire

// [tb/ssr_master_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ssr_master_model (
	output var logic sck,
	output var logic sd
);
	initial begin
		sck = 1'b0;
		sd = 1'b1;
	end
	// Clock idle low between frames, data LSB first
	task automatic send(input logic [8:0] d, input int n);
		for (int i = 0; i < n; i++) begin
			sd = d[i];
			#100 sck = 1'b1;
			#100 sck = 1'b0;
		end
		sd = ~sd;
	endtask
endmodule
`default_nettype wire

// [tb/ssr_receiver_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module ssr_receiver_asserts (
	input wire logic       clk,
	input wire logic       rstn,
	input wire logic       shift_clk_pin,
	input wire logic       data_pin,
	input wire logic       core_sleeping,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	input wire logic       receive_complete_flag,
	input wire logic       core_irq,
	input wire logic       core_wake,
	input wire logic       vector_branch,
	input wire logic       event_irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	logic [3:0] since_hi;
	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			since_hi <= 4'hF;
		else if (shift_clk_pin)
			since_hi <= 4'h0;
		else if (since_hi != 4'hF)
			since_hi <= since_hi + 4'h1;
	end
	rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
		else $error("read data not zero outside a read");
	wake_sleep_a: assert property (core_wake |-> $past(core_sleeping))
		else $error("wake while awake");
	wake_flag_a: assert property (core_wake |->
		receive_complete_flag || $past(receive_complete_flag))
		else $error("wake without a word");
	irq_flag_a: assert property (core_irq |->
		receive_complete_flag || $past(receive_complete_flag))
		else $error("interrupt without a word");
	branch_def_a: assert property (vector_branch ==
		(core_irq && $past(core_sleeping)))
		else $error("vector branch mismatch");
	wake_irq_a: assert property (core_irq && $past(core_sleeping)
		|-> core_wake)
		else $error("no wake on interrupt");
	flag_fall_a: assert property ($fell(receive_complete_flag)
		|-> $past(rd) || $past(rd, 2))
		else $error("flag cleared without read");
	flag_rise_a: assert property ($rose(receive_complete_flag)
		|-> since_hi <= 4'h8)
		else $error("flag rose without shift clock");
endmodule
bind ssr_receiver ssr_receiver_asserts u_chk (.clk(clk), .rstn(rstn),
	.shift_clk_pin(shift_clk_pin), .data_pin(data_pin),
	.core_sleeping(core_sleeping), .addr(addr), .wdata(wdata), .wr(wr),
	.rd(rd), .rdata(rdata), .receive_complete_flag(receive_complete_flag),
	.core_irq(core_irq), .core_wake(core_wake),
	.vector_branch(vector_branch), .event_irq(event_irq));
`default_nettype wire

// [tb/tb_sync_slave_serial_receiver.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_sync_slave_serial_receiver;
	logic       clk, rstn, slp, wr, rd, flag, irq, wake, vec, eirq;
	wire        sck, sd;
	logic [3:0] addr;
	logic [7:0] wdata, rdata, v, cfg;
	logic [8:0] w [3];
	int         n_fail = 0, n_checks = 0, cyc = 0;
	ssr_receiver u_dut (.clk(clk), .rstn(rstn), .shift_clk_pin(sck),
		.data_pin(sd), .core_sleeping(slp), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .receive_complete_flag(flag),
		.core_irq(irq), .core_wake(wake), .vector_branch(vec),
		.event_irq(eirq));
	ssr_master_model u_mst (.sck(sck), .sd(sd));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	task automatic chk(input string nm, input logic [8:0] s, e);
		n_checks++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] a, output logic [7:0] r);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 r = rdata;
	endtask
	task automatic word(input logic [8:0] d, input int n);
		u_mst.send(d, n);
		settle(8);
	endtask
	initial begin
		rstn = 1'b0;
		slp = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		v = 8'($urandom(32'hA0EC));
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		rreg(4'hF, v);
		chk("unmapped", v, 9'h000);
		wreg(4'h2, 8'h10);
		wreg(4'h3, 8'h01);
		wreg(4'h4, 8'hC0);
		wreg(4'h6, 8'h03);
		for (int m = 0; m < 2; m++) begin
			cfg = 8'h90 | (m ? 8'h40 : 8'h00) | (8'($urandom) & 8'h20);
			wreg(4'h0, cfg);
			for (int i = 0; i < 3; i++) begin
				w[i] = 9'($urandom);
				word(w[i], 8 + m);
			end
			chk("flag", flag, 9'h001);
			chk("irq", irq, 9'h001);
			rreg(4'h0, v);
			chk("overrun", v[1], 9'h001);
			if (m) chk("ninth", v[0], w[0][8]);
			for (int i = 0; i < 2; i++) begin
				rreg(4'h1, v);
				chk("data", v, w[i][7:0]);
				rreg(4'h0, v);
				if (m && i == 0) chk("next_ninth", v[0], w[1][8]);
			end
			chk("flag_clear", flag, 9'h000);
			word(9'h0A5, 8 + m);
			chk("blocked", flag, 9'h000);
			wreg(4'h6, 8'h00);
			settle(2);
			chk("masked", eirq, 9'h000);
			wreg(4'h6, 8'h03);
			rreg(4'h5, v);
			chk("events", v, 9'h003);
			chk("event_irq", eirq, 9'h001);
			wreg(4'h5, 8'h03);
			rreg(4'h5, v);
			chk("events_clr", v, 9'h000);
			chk("event_irq_clr", eirq, 9'h000);
			wreg(4'h0, cfg & 8'hEF);
			rreg(4'h0, v);
			chk("overrun_clr", v[1], 9'h000);
		end
		slp <= 1'b1;
		wreg(4'h4, 8'h00);
		wreg(4'h0, 8'h90);
		word(9'h03C, 8);
		chk("wake", wake, 9'h001);
		chk("irq_gated", irq, 9'h000);
		wreg(4'h4, 8'hC0);
		settle(2);
		chk("branch", vec, 9'h001);
		rreg(4'h1, v);
		chk("sleep_data", v, 9'h03C);
		tally_and_finish();
	end
endmodule
`default_nettype wire
